// ### e_clock_enable.sv
// E clock rate enable: one-cycle pulse every DIV cycles of clk.
// Assumes a single clock domain; DIV of at least 1.
`timescale 1ns/1ps
module e_clock_enable #(
  parameter int DIV = memory_map_pkg::E_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [15:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (cnt_r == 16'(DIV - 1)) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : e_clock_enable

// ### ext_bus_model.sv
// External memory on the multiplexed bus: answers reads, records writes.
// Assumes the strobe cycle carries the low address on the port.
`timescale 1ns/1ps
module ext_bus_model #(
  parameter int HOLD = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic rd,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  input wire logic oe,
  output logic [7:0] din,
  output logic [15:0] waddr,
  output logic [7:0] wdata
);
  logic [15:0] a_r;
  logic rd_r;
  int cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_r <= 16'h0000;
      rd_r <= 1'b0;
      cnt_r <= 0;
      din <= 8'h00;
      waddr <= 16'h0000;
      wdata <= 8'h00;
    end else if (strobe) begin
      a_r <= {hi, lo};
      rd_r <= rd;
      cnt_r <= HOLD;
      din <= rd ? (hi ^ lo ^ 8'h3C) : ~din;
    end else begin
      cnt_r <= (cnt_r > 0) ? cnt_r - 1 : 0;
      // Released lines toggle so stale data never looks valid
      if (!(cnt_r > 0 && rd_r))
        din <= ~din;
      if (cnt_r > 0 && !rd_r && oe) begin
        waddr <= a_r;
        wdata <= lo;
      end
    end
  end
endmodule : ext_bus_model

// ### memory_map_decoder.sv
// Memory map decoder: picks the internal resource or external bus per access,
// places vectors per mode, and holds mode, page map and enable registers.
// Assumes an AHB-Lite master on hclk and a CPU-side single-access port.
//
// Functional notes
// RULE1 - Single-chip maps never drive address, strobe or data on external pins.
// RULE2 - Expanded maps send every unclaimed address to the external bus.
// RULE3 - An enabled internal resource wins over an overlapping external device.
// RULE4 - Internal reads ignore external pin data and return internal data only.
// RULE5 - Writes to internal locations also drive data onto the multiplexed port.
// RULE6 - External devices must not drive the port during internal writes.
// RULE7 - Expanded maps drive read/write, strobe, address, data on every access.
// RULE8 - Bootstrap uses the single-chip map plus boot memory from BF40.
// RULE9 - Bootstrap vector fetches come from BFC0 through BFFF in boot memory.
// RULE10 - Test mode uses the expanded map with vectors from external BFC0-BFFF.
// RULE11 - Software may relocate RAM and control-register block via the page map.
// RULE12 - Page map high nibble selects RAM page, low nibble register page.
// RULE13 - Page map takes one write within 64 E cycles, then read-only; the code also accepts page map writes at any time in test mode.
// RULE14 - Register block beats RAM and ROM; RAM beats ROM; losers vanish.
// RULE15 - Unused register-block locations read the idle bus value only.
// RULE16 - Operating mode is latched at reset and held until rewritten.
`timescale 1ns/1ps
module memory_map_decoder #(
  parameter int DATA_WAIT = memory_map_pkg::DATA_WAIT,
  parameter int E_DIV = memory_map_pkg::E_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] mode_pins,
  input wire logic cpu_req,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_vector,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_ready,
  output logic [7:0] cpu_rdata,
  output memory_map_pkg::sel_t mem_sel,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  input wire logic [7:0] ctl_rdata,
  input wire logic [7:0] ram_rdata,
  input wire logic [7:0] boot_rdata,
  input wire logic [7:0] rom_rdata,
  input wire logic [7:0] ee_rdata,
  output logic address_strobe,
  output logic bus_read,
  output logic [7:0] ext_addr_hi,
  output logic [7:0] multiplexed_addr_data_port_out,
  output logic multiplexed_addr_data_port_oe,
  input wire logic [7:0] multiplexed_addr_data_port_in,
  output memory_map_pkg::op_mode_t op_mode
);
  memory_map_pkg::op_mode_t mode_r;
  memory_map_pkg::acc_state_t state_r;
  memory_map_pkg::sel_t sel_r;
  memory_map_pkg::sel_t dec;
  logic rboot_r;
  logic [4:0] mode_low_r;
  logic [7:0] page_r;
  logic [3:0] enable_r;
  logic page_written_r;
  logic window_open_r;
  logic [6:0] e_cnt_r;
  logic strap_done_r;
  logic [2:0] strap_cnt_r;
  logic [1:0] mode_pins_s;
  logic [7:0] port_in_s;
  logic e_tick;
  logic take;
  logic wr_pend_r;
  logic [15:0] wr_idx_r;
  logic wr_mode;
  logic wr_page;
  logic wr_enable;
  logic [7:0] d;
  logic exp_map;
  logic [15:0] eff_addr;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic write_r;
  logic [7:0] wait_r;
  logic [7:0] rd_mux;
  logic address_strobe_r;
  logic bus_read_r;
  logic [7:0] ext_addr_hi_r;
  logic [7:0] port_out_r;
  logic port_oe_r;
  logic [7:0] cpu_rdata_r;
  logic cpu_ready_r;
  logic mem_wr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;

  // Priority chain: control block, RAM, boot, ROM, EEPROM, then external
  function automatic memory_map_pkg::sel_t decode(
    input logic [15:0] a,
    input memory_map_pkg::op_mode_t m,
    input logic [7:0] page,
    input logic [3:0] en,
    input logic rboot
  );
    memory_map_pkg::sel_t s;
    s = '0;
    // RULE12 page nibble match
    if (a[15:12] == page[3:0] && a[11:6] == 6'h00) begin
      s.ctl = 1'b1;
    end else if (a[15:12] == page[7:4] && a[11:9] == 3'h0) begin
      s.ram = 1'b1;
    end else if (rboot && a >= memory_map_pkg::BOOT_BASE && a <= memory_map_pkg::BOOT_LAST) begin
      s.boot = 1'b1;
    end else if ((en[memory_map_pkg::BIT_ROM_EN] || m == memory_map_pkg::MODE_SINGLE)
                 && a >= memory_map_pkg::ROM_BASE) begin
      s.rom = 1'b1;
    end else if (en[memory_map_pkg::BIT_EE_EN] && a >= memory_map_pkg::EE_BASE
                 && a <= memory_map_pkg::EE_LAST) begin
      s.eeprom = 1'b1;
    end else if (m == memory_map_pkg::MODE_EXPANDED || m == memory_map_pkg::MODE_TEST) begin
      s.external_region = 1'b1;
    end
    return s;
  endfunction : decode

  // Holes in the 64-byte control block
  function automatic logic ctl_unused(input logic [5:0] off);
    return off == 6'h01 || off == 6'h06 || (off >= 6'h36 && off <= 6'h38);
  endfunction : ctl_unused

  function automatic logic [7:0] reg_value(
    input logic [15:0] idx,
    input logic [7:0] mode_byte,
    input logic [7:0] page,
    input logic [3:0] en
  );
    case (idx)
      memory_map_pkg::IDX_MODE: return mode_byte;
      memory_map_pkg::IDX_PAGE: return page;
      memory_map_pkg::IDX_ENABLE: return {4'h0, en};
      default: return 8'h00;
    endcase
  endfunction : reg_value

  sync3 #(.W(2)) u_mode_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(mode_pins),
    .q(mode_pins_s)
  );

  sync3 #(.W(8)) u_port_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(multiplexed_addr_data_port_in),
    .q(port_in_s)
  );

  e_clock_enable #(.DIV(E_DIV)) u_e_clk (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(e_tick)
  );

  assign exp_map = mode_r == memory_map_pkg::MODE_EXPANDED || mode_r == memory_map_pkg::MODE_TEST;
  assign take = hsel && htrans[1] && hready;
  assign d = hwdata[7:0];
  assign wr_mode = wr_pend_r && wr_idx_r == memory_map_pkg::IDX_MODE;
  assign wr_page = wr_pend_r && wr_idx_r == memory_map_pkg::IDX_PAGE;
  assign wr_enable = wr_pend_r && wr_idx_r == memory_map_pkg::IDX_ENABLE;

  // RULE9 vector remap boot
  // RULE10 vector remap test
  always_comb begin
    eff_addr = cpu_addr;
    if (cpu_vector && mode_r[1] && cpu_addr[15:6] == memory_map_pkg::VEC_BASE[15:6]) begin
      eff_addr = {memory_map_pkg::VEC_BOOT[15:6], cpu_addr[5:0]};
    end
  end

  // RULE14 resource priority chain
  // RULE8 boot memory enable
  assign dec = decode(eff_addr, mode_r, page_r, enable_r, rboot_r);

  // RULE4 internal data only
  // RULE15 idle bus on holes
  always_comb begin
    rd_mux = memory_map_pkg::IDLE_BUS;
    if (sel_r.ctl) begin
      rd_mux = ctl_unused(addr_r[5:0]) ? memory_map_pkg::IDLE_BUS : ctl_rdata;
    end else if (sel_r.ram) begin
      rd_mux = ram_rdata;
    end else if (sel_r.boot) begin
      rd_mux = boot_rdata;
    end else if (sel_r.rom) begin
      rd_mux = rom_rdata;
    end else if (sel_r.eeprom) begin
      rd_mux = ee_rdata;
    end else if (sel_r.external_region) begin
      rd_mux = port_in_s;
    end
  end

  // RULE16 strap latch and mode bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= memory_map_pkg::MODE_SINGLE;
      rboot_r <= 1'b0;
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 3'd1;
      if (strap_cnt_r == 3'(memory_map_pkg::STRAP_SETTLE - 1)) begin
        mode_r <= memory_map_pkg::op_mode_t'(mode_pins_s);
        rboot_r <= mode_pins_s == memory_map_pkg::MODE_BOOT;
        strap_done_r <= 1'b1;
      end
    end else if (wr_mode) begin
      // Special bit may only be cleared; mode bits lock once normal
      mode_r <= memory_map_pkg::op_mode_t'({mode_r[1] & d[memory_map_pkg::BIT_SPECIAL],
                                            mode_r[1] ? d[memory_map_pkg::BIT_EXPANDED] : mode_r[0]});
      if (mode_r[1]) begin
        rboot_r <= d[memory_map_pkg::BIT_BOOT_ROM];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_low_r <= memory_map_pkg::MODE_LOW_RST;
    end else if (wr_mode) begin
      mode_low_r <= d[4:0];
    end
  end

  // RULE13 64 E-cycle window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      e_cnt_r <= '0;
      window_open_r <= 1'b1;
    end else if (e_tick && window_open_r) begin
      e_cnt_r <= e_cnt_r + 7'd1;
      if (e_cnt_r == 7'(memory_map_pkg::MAP_WINDOW_E - 1)) begin
        window_open_r <= 1'b0;
      end
    end
  end

  // RULE11 page relocation
  // RULE13 single write only, except in test mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_r <= memory_map_pkg::PAGE_RST;
      page_written_r <= 1'b0;
    end else if (wr_page && ((window_open_r && !page_written_r) || mode_r == memory_map_pkg::MODE_TEST)) begin
      page_r <= d;
      page_written_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= memory_map_pkg::ENABLE_RST;
    end else if (wr_enable) begin
      enable_r <= d[3:0];
    end
  end

  // Zero-wait slave; a read right after a write to the same register sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
      hrdata_r <= '0;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r <= take && hwrite && haddr[31:18] == 14'h0000 && haddr[1:0] == 2'b00;
      wr_idx_r <= haddr[17:2];
      if (take && !hwrite) begin
        hrdata_r <= '0;
        if (haddr[31:18] == 14'h0000 && haddr[1:0] == 2'b00) begin
          hrdata_r <= {24'h000000,
                       reg_value(haddr[17:2], {rboot_r, mode_r, mode_low_r}, page_r, enable_r)};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= memory_map_pkg::ST_IDLE;
      sel_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      write_r <= 1'b0;
      wait_r <= '0;
      address_strobe_r <= 1'b0;
      bus_read_r <= 1'b1;
      ext_addr_hi_r <= '0;
      port_out_r <= '0;
      port_oe_r <= 1'b0;
      cpu_rdata_r <= '0;
      cpu_ready_r <= 1'b0;
      mem_wr_r <= 1'b0;
    end else begin
      case (state_r)
        memory_map_pkg::ST_IDLE: begin
          if (cpu_req && strap_done_r) begin
            // RULE3 internal wins
            // RULE2 unclaimed goes external
            sel_r <= dec;
            addr_r <= eff_addr;
            wdata_r <= cpu_wdata;
            write_r <= cpu_write;
            state_r <= memory_map_pkg::ST_ADDR;
            // RULE7 strobe every access
            // RULE1 quiet pins single-chip
            if (exp_map) begin
              address_strobe_r <= 1'b1;
              bus_read_r <= !cpu_write;
              ext_addr_hi_r <= eff_addr[15:8];
              port_out_r <= eff_addr[7:0];
              port_oe_r <= 1'b1;
            end
          end
        end
        memory_map_pkg::ST_ADDR: begin
          address_strobe_r <= 1'b0;
          wait_r <= '0;
          // RULE5 write data out
          port_out_r <= exp_map ? wdata_r : 8'h00;
          port_oe_r <= exp_map && write_r;
          state_r <= memory_map_pkg::ST_DATA;
        end
        memory_map_pkg::ST_DATA: begin
          wait_r <= wait_r + 8'd1;
          if (wait_r == 8'(DATA_WAIT - 1)) begin
            cpu_rdata_r <= write_r ? wdata_r : rd_mux;
            cpu_ready_r <= 1'b1;
            mem_wr_r <= write_r && !sel_r.external_region;
            state_r <= memory_map_pkg::ST_DONE;
          end
        end
        memory_map_pkg::ST_DONE: begin
          cpu_ready_r <= 1'b0;
          mem_wr_r <= 1'b0;
          sel_r <= '0;
          port_oe_r <= 1'b0;
          bus_read_r <= 1'b1;
          state_r <= memory_map_pkg::ST_IDLE;
        end
        default: begin
          state_r <= memory_map_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;
  assign cpu_ready = cpu_ready_r;
  assign cpu_rdata = cpu_rdata_r;
  assign mem_sel = sel_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign mem_wr = mem_wr_r;
  assign address_strobe = address_strobe_r;
  assign bus_read = bus_read_r;
  assign ext_addr_hi = ext_addr_hi_r;
  assign multiplexed_addr_data_port_out = port_out_r;
  assign multiplexed_addr_data_port_oe = port_oe_r;
  assign op_mode = mode_r;

  property p_quiet_pins;
    @(posedge hclk) disable iff (!hresetn)
    !exp_map && state_r == memory_map_pkg::ST_IDLE |=> !address_strobe_r && !port_oe_r;
  endproperty
  a_quiet_pins: assert property (p_quiet_pins) else $error("pins driven in single-chip map"); // RULE1

  property p_unclaimed_ext;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_ADDR && exp_map && !(sel_r.ctl || sel_r.ram || sel_r.boot
      || sel_r.rom || sel_r.eeprom) |-> sel_r.external_region;
  endproperty
  a_unclaimed_ext: assert property (p_unclaimed_ext) else $error("unclaimed address not external"); // RULE2

  property p_one_winner;
    @(posedge hclk) disable iff (!hresetn) $onehot0(sel_r);
  endproperty
  a_one_winner: assert property (p_one_winner) else $error("more than one resource selected"); // RULE3

  property p_internal_read;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_DATA && wait_r == 8'(DATA_WAIT - 1) && !write_r && sel_r.ram
      |=> cpu_rdata_r == $past(ram_rdata);
  endproperty
  a_internal_read: assert property (p_internal_read) else $error("internal read took other data"); // RULE4

  property p_write_out;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_ADDR && exp_map && write_r
      |=> port_oe_r && port_out_r == wdata_r [*2];
  endproperty
  a_write_out: assert property (p_write_out) else $error("write data not on port"); // RULE5

  property p_strobe_all;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_IDLE && cpu_req && strap_done_r && exp_map
      |=> address_strobe_r && port_oe_r && ext_addr_hi_r == addr_r[15:8] ##1 !address_strobe_r;
  endproperty
  a_strobe_all: assert property (p_strobe_all) else $error("strobe or address missing"); // RULE7

  property p_boot_vector;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_IDLE && cpu_req && strap_done_r && cpu_vector && rboot_r
      && mode_r == memory_map_pkg::MODE_BOOT && cpu_addr[15:6] == memory_map_pkg::VEC_BASE[15:6]
      |=> sel_r.boot && addr_r[15:6] == memory_map_pkg::VEC_BOOT[15:6];
  endproperty
  a_boot_vector: assert property (p_boot_vector) else $error("boot vector not from boot memory"); // RULE9

  property p_page_locked;
    @(posedge hclk) disable iff (!hresetn)
    (!window_open_r || page_written_r) && mode_r != memory_map_pkg::MODE_TEST |=> $stable(page_r);
  endproperty
  a_page_locked: assert property (p_page_locked) else $error("page map changed after lock"); // RULE13

  property p_hole_idle;
    @(posedge hclk) disable iff (!hresetn)
    state_r == memory_map_pkg::ST_DATA && wait_r == 8'(DATA_WAIT - 1) && !write_r && sel_r.ctl
      && ctl_unused(addr_r[5:0]) |=> cpu_rdata_r == memory_map_pkg::IDLE_BUS;
  endproperty
  a_hole_idle: assert property (p_hole_idle) else $error("hole returned driven data"); // RULE15
endmodule : memory_map_decoder

// ### memory_map_pkg.sv
// Constants and types shared by the memory map decoder and its helpers.
// Assumes a 40 MHz hclk from which the E clock rate is derived.
package memory_map_pkg;
  localparam int HCLK_HZ = 40_000_000;
  localparam int E_CLOCK_HZ = 2_000_000;
  localparam int E_DIV = HCLK_HZ / E_CLOCK_HZ;
  localparam int MAP_WINDOW_E = 64;
  // Strap is read only once the pin synchroniser has filled after release
  localparam int STRAP_SETTLE = 5;
  // Three sync stages plus the port turnaround before external data is usable
  localparam int DATA_WAIT = 5;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_MODE = 16'h103C;
  localparam logic [15:0] IDX_PAGE = 16'h103D;
  localparam logic [15:0] IDX_ENABLE = 16'h103F;

  localparam logic [4:0] MODE_LOW_RST = 5'h00;
  localparam logic [7:0] PAGE_RST = 8'h01;
  localparam logic [3:0] ENABLE_RST = 4'hF;

  localparam int BIT_BOOT_ROM = 7;
  localparam int BIT_SPECIAL = 6;
  localparam int BIT_EXPANDED = 5;
  localparam int BIT_ROM_EN = 1;
  localparam int BIT_EE_EN = 0;

  localparam logic [15:0] ROM_BASE = 16'hD000;
  localparam logic [15:0] BOOT_BASE = 16'hBF40;
  localparam logic [15:0] BOOT_LAST = 16'hBFFF;
  localparam logic [15:0] EE_BASE = 16'hB600;
  localparam logic [15:0] EE_LAST = 16'hB7FF;
  localparam logic [15:0] VEC_BASE = 16'hFFC0;
  localparam logic [15:0] VEC_BOOT = 16'hBFC0;
  localparam logic [7:0] IDLE_BUS = 8'hFF;

  // Encoding is {special, expanded}
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPANDED = 2'b01,
    MODE_BOOT = 2'b10,
    MODE_TEST = 2'b11
  } op_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } acc_state_t;

  typedef struct packed {
    logic ctl;
    logic ram;
    logic boot;
    logic rom;
    logic eeprom;
    logic external_region;
  } sel_t;
endpackage : memory_map_pkg

// ### sync3.sv
// Three-stage synchroniser for pin inputs.
// Assumes d is asynchronous to clk; q moves only once stages two and three agree.
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (s2_r == s3_r) begin
      q <= s3_r;
    end
  end
endmodule : sync3

// ### tb.sv
// Self-checking bench for the memory map decoder and its external bus.
// Assumes one AHB-Lite slave and internal read data held constant during each access.
`timescale 1ns/1ps
module tb;
  localparam int DW = 5;
  localparam logic [5:0] S_CTL = 6'h20;
  localparam logic [5:0] S_RAM = 6'h10;
  localparam logic [5:0] S_BOOT = 6'h08;
  localparam logic [5:0] S_ROM = 6'h04;
  localparam logic [5:0] S_EE = 6'h02;
  localparam logic [5:0] S_EXT = 6'h01;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] mode_pins = 2'h0;
  logic cpu_req = 1'b0;
  logic cpu_write = 1'b0;
  logic cpu_vector = 1'b0;
  logic [15:0] cpu_addr = 16'h0;
  logic [7:0] cpu_wdata = 8'h0;
  logic [7:0] ram_d = 8'hA2;
  logic [7:0] ctl_d = 8'hC1;
  logic [7:0] mwd;
  logic hresp_s;
  logic hready, hreadyout, cpu_ready, mem_wr, stb_o, bus_read, oe, wr_seen;
  logic [31:0] hrdata, r;
  logic [7:0] cpu_rdata, ext_addr_hi, pout, pin, wdata, hi_s, lo_s, rd_s;
  logic [15:0] waddr, addr_s, mem_addr;
  logic [5:0] sel_s;
  memory_map_pkg::sel_t mem_sel;
  memory_map_pkg::op_mode_t op_mode;
  int n_fail = 0;
  int check_count = 0;
  int stb, noe;

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  memory_map_decoder #(.DATA_WAIT(DW), .E_DIV(1)) u_memory_map_decoder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp_s), .mode_pins(mode_pins),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
    .cpu_vector(cpu_vector), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
    .cpu_rdata(cpu_rdata), .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_wdata(mwd),
    .mem_wr(mem_wr), .ctl_rdata(ctl_d), .ram_rdata(ram_d), .boot_rdata(8'hB3),
    .rom_rdata(8'hD4), .ee_rdata(8'hE5), .address_strobe(stb_o),
    .bus_read(bus_read), .ext_addr_hi(ext_addr_hi),
    .multiplexed_addr_data_port_out(pout), .multiplexed_addr_data_port_oe(oe),
    .multiplexed_addr_data_port_in(pin), .op_mode(op_mode)
  );

  ext_bus_model #(.HOLD(DW)) u_ext_bus_model (
    .clk(hclk), .rst_n(hresetn), .strobe(stb_o), .rd(bus_read), .hi(ext_addr_hi),
    .lo(pout), .oe(oe), .din(pin), .waddr(waddr), .wdata(wdata)
  );

  function automatic logic [7:0] ev(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : ev

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task conclude;
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus

  task rreg(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
    chk(hresp_s, 1'b0);
  endtask : rreg

  task do_reset(input logic [1:0] m);
    @(posedge hclk);
    hresetn <= 1'b0;
    mode_pins <= m;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Strap reaches the mode register five edges after release
    repeat (6) @(posedge hclk);
    chk(op_mode, m);
  endtask : do_reset

  task acc(input logic [15:0] a, input logic w, v, input logic [7:0] d, input logic [5:0] es,
           input logic [7:0] er, input int ns);
    int k;
    k = 0;
    stb = 0;
    noe = 0;
    wr_seen = 1'b0;
    @(posedge hclk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    cpu_write <= w;
    cpu_vector <= v;
    cpu_wdata <= d;
    do begin
      @(posedge hclk);
      #1;
      k++;
      if (stb_o === 1'b1) begin
        stb++;
        hi_s = ext_addr_hi;
        lo_s = pout;
      end
      if (oe === 1'b1)
        noe++;
      if (mem_wr === 1'b1)
        wr_seen = 1'b1;
      if (k == 1) begin
        sel_s = mem_sel;
        addr_s = mem_addr;
      end
    end while (cpu_ready !== 1'b1);
    rd_s = cpu_rdata;
    @(posedge hclk);
    cpu_req <= 1'b0;
    chk(k, 2 + DW);
    chk(sel_s, es);
    chk(rd_s, er);
    chk(stb, ns);
    chk(mwd, d);
    if (ns == 0)
      chk(noe, 0);
  endtask : acc

  task t_single;
    do_reset(2'h0);
    rreg(32'h40F4, 32'h01);
    rreg(32'h40FC, 32'h0F);
    rreg(32'h40F0, 32'h00);
    rreg(32'h0800, 32'h00);
    repeat (70) @(posedge hclk);
    bus(1'b1, 32'h40F4, 32'h55);
    rreg(32'h40F4, 32'h01);
    acc(16'h0010, 1'b0, 1'b0, 8'h00, S_RAM, 8'hA2, 0);
    acc(16'h1001, 1'b0, 1'b0, 8'h00, S_CTL, 8'hFF, 0);
    acc(16'h4000, 1'b1, 1'b0, 8'h77, 6'h00, 8'h77, 0);
    acc(16'hE000, 1'b0, 1'b0, 8'h00, S_ROM, 8'hD4, 0);
    acc(16'hB610, 1'b0, 1'b0, 8'h00, S_EE, 8'hE5, 0);
  endtask : t_single

  task t_expanded;
    do_reset(2'h1);
    bus(1'b1, 32'h40F4, 32'hDD);
    bus(1'b1, 32'h40F4, 32'h11);
    rreg(32'h40F4, 32'hDD);
    rreg(32'h40F0, 32'h20);
    // Model drives the port on these reads; internal data must win
    acc(16'hD005, 1'b0, 1'b0, 8'h00, S_CTL, 8'hC1, 1);
    ram_d <= 8'h5A;
    acc(16'hD100, 1'b0, 1'b0, 8'h00, S_RAM, 8'h5A, 1);
    acc(16'hD300, 1'b0, 1'b0, 8'h00, S_ROM, 8'hD4, 1);
    acc(16'h4123, 1'b0, 1'b0, 8'h00, S_EXT, ev(16'h4123), 1);
    chk({hi_s, lo_s}, 16'h4123);
    acc(16'h0020, 1'b0, 1'b0, 8'h00, S_EXT, ev(16'h0020), 1);
    acc(16'hD120, 1'b1, 1'b0, 8'hA5, S_RAM, 8'hA5, 1);
    chk(wr_seen, 1'b1);
    chk({waddr, wdata}, 24'hD120A5);
  endtask : t_expanded

  task t_special;
    do_reset(2'h2);
    rreg(32'h40F0, 32'hC0);
    acc(16'hBF50, 1'b0, 1'b0, 8'h00, S_BOOT, 8'hB3, 0);
    acc(16'hFFFE, 1'b0, 1'b1, 8'h00, S_BOOT, 8'hB3, 0);
    chk(addr_s, 16'hBFFE);
    acc(16'h0040, 1'b0, 1'b0, 8'h00, S_RAM, 8'h5A, 0);
    do_reset(2'h3);
    rreg(32'h40F0, 32'h60);
    acc(16'hFFFE, 1'b0, 1'b1, 8'h00, S_EXT, ev(16'hBFFE), 1);
    chk({hi_s, lo_s}, 16'hBFFE);
  endtask : t_special

  initial begin
    t_single();
    t_expanded();
    t_special();
    conclude();
  end

  // The tests need about 300 cycles; over sixty times that means a hang
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    conclude();
  end
endmodule : tb
